// *** test/nco_checker.sv ***
// Concurrent checks on the oscillator ports
`timescale 1ns/100ps
`default_nettype none
module nco_checker (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_pin_output_enable,
  input wire logic i_output_polarity,
  input wire logic i_pulse_mode_select,
  input wire logic i_flag_clear,
  input wire logic o_nco_out,
  input wire logic o_pin_out,
  input wire logic o_pin_oe_n,
  input wire logic o_overflow_pulse,
  input wire logic o_overflow_interrupt_flag
);
  wire logic pm = i_pulse_mode_select, pol = i_output_polarity, pe = i_pin_output_enable;
  wire logic ovf = o_overflow_pulse, flg = o_overflow_interrupt_flag, out = o_nco_out;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Output shows mode and polarity a cycle late, so both are held first
  sequence fdc_held;
    !pm ##1 !pm && $stable(pol);
  endsequence
  duty_tog_a: assert property (fdc_held |=> $changed(out) == ovf) else $error("toggle");
  pf_start_a: assert property (pm ##1 ovf |-> out != $past(pol)) else $error("pulse");
  flag_set_a: assert property (ovf |-> flg) else $error("flag not set");
  flag_hold_a: assert property (flg && !i_flag_clear |=> flg) else $error("flag lost");
  flag_clr_a: assert property (i_flag_clear |=> !flg || ovf) else $error("flag stuck");
  pin_oe_a: assert property (o_pin_oe_n == !pe) else $error("enable wrong");
  pin_off_a: assert property (!pe |=> !o_pin_out) else $error("pin driven");
  pin_on_a: assert property (pe |=> o_pin_out == out) else $error("pin wrong");
endmodule
bind nco_top nco_checker chk (.*);
`default_nettype wire

// *** test/nco_sink.sv ***
// Peripheral model counting rising edges of the shaped output
`timescale 1ns/100ps
`default_nettype none
module nco_sink (
  input wire logic i_ref_clk,
  input wire logic i_nco_out,
  output var int o_rises
);
  bit last_q;
  always @(posedge i_ref_clk) last_q <= i_nco_out;
  always @(posedge i_ref_clk) o_rises <= o_rises + int'(i_nco_out && !last_q);
endmodule
`default_nettype wire

// *** test/nco_tb.sv ***
// Self-checking bench for the oscillator block
`timescale 1ns/100ps
`default_nettype none
module numerically_controlled_oscillator_tb;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, pe = 1'b0, pm = 1'b0, pol = 1'b0, out, flag;
  logic [7:0] dat = 8'h00, il, ih, al, ah, au;
  logic [5:0] we = 6'h00;
  logic [3:0] osc = 4'h0;
  logic [2:0] pws = 3'h0;
  logic [1:0] src = 2'h0;
  int n_errors = 0, checked = 0, rises, k;
  wire logic [19:0] acc = {au[3:0], ah, al};
  nco_top dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_internal_fast_oscillator(osc[0]),
    .i_system_oscillator(osc[1]), .i_logic_cell_one_output(osc[2]),
    .i_external_clock_pin(osc[3]), .i_module_enable_bit(en), .i_pin_output_enable(pe),
    .i_output_polarity(pol), .i_pulse_mode_select(pm), .i_pulse_width_select(pws),
    .i_clock_source_select(src), .i_wr_data(dat), .i_increment_low_byte_wr(we[0]),
    .i_increment_high_byte_wr(we[1]), .i_accumulator_low_byte_wr(we[2]),
    .i_accumulator_high_byte_wr(we[3]), .i_accumulator_upper_bits_wr(we[4]),
    .i_flag_clear(we[5]), .o_increment_low_byte(il), .o_increment_high_byte(ih),
    .o_accumulator_low_byte(al), .o_accumulator_high_byte(ah), .o_accumulator_upper_bits(au),
    .o_nco_out(out), .o_pin_out(), .o_pin_oe_n(), .o_overflow_pulse(),
    .o_overflow_interrupt_flag(flag));
  nco_sink sink (.i_ref_clk(clk), .i_nco_out(out), .o_rises(rises));
  task automatic chk(input string n, input logic [19:0] e, g);
    checked++;
    n_errors += int'(g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    {we, dat} <= {6'(1 << i), d};
    @(posedge clk);
    we <= 6'h00;
    @(posedge clk);
  endtask
  // Three cycles per level keeps each edge past the two-flop sampler
  task automatic tick(input int s, input int n);
    src <= 2'(s);
    repeat (2 * n) begin
      osc[s] <= !osc[s];
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr(1, 8'h80);
    chk("inc", 20'h08001, {ih, il});
    {en, pe} <= 2'b11;
    for (k = 0; k < 4; k++) tick(k, 8);
    chk("acc", 20'h00020, acc);
    chk("fdc", 20'h3, {flag, rises[0]});
    wr(5, 8'h00);
    chk("clr", 20'h0, flag);
    wr(0, 8'h00);
    tick(3, 3);
    chk("buf", 20'h18022, acc);
    // Width four stays well inside the 32-tick overflow period
    {pm, pol, pws} <= 5'b11010;
    tick(3, 32);
    chk("pf on", 20'h0, out);
    tick(3, 1);
    chk("pf off", 20'h1, out);
    wr(2, 8'h5a);
    wr(3, 8'h3c);
    wr(4, 8'hf7);
    chk("acc wr", 20'h73c5a, acc);
    chk("accu", 20'h00007, au);
    finish_test();
  end
endmodule
`default_nettype wire

// *** verilog/nco_pkg.sv ***
// Constants and state type for the numerically controlled oscillator
// How it works
// - Phase accumulator is twenty bits; carry out of bit 19 marks overflow.
// - Increment is sixteen bits built from low and high byte registers.
// - Each selected oscillator rising edge adds buffered increment to accumulator.
// - Accumulator carry is the raw output pulse; f = fclk*inc/2^20.
// - Adder runs on selected oscillator edges, not on processor clock.
// - Four clock sources chosen by the clock source select field.
// - Enabled: low byte write loads buffer on second following oscillator edge.
// - Increment bytes are read/write; working buffer is hidden.
// - Disabled: any increment byte write loads the buffer immediately.
// - Fixed duty mode toggles output on every overflow.
// - Pulse mode select bit clear gives fixed duty, set gives pulse frequency.
// - Pulse mode: output active from overflow edge for selected width.
// - Active and inactive levels follow the output polarity bit.
// - Pulse width in oscillator periods comes from three-bit select field.
// - Every accumulator overflow raises an interrupt event.
// - Shaped output always goes inside; to the pin only when enabled.
// - Accumulator readable and writable as low, high and upper four bits.
// - Clock source codes: 00 fast osc, 01 system osc, 10 cell, 11 pin.
// - Pulse width code n gives two to the n oscillator periods.
// - Polarity set gives active-low inverted output; clear gives active-high.
// - Overflow flag sets on each overflow and holds until software clears.
package nco_pkg;
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int PW_CNT_W = 8;
  localparam int SYNC_W = 2;
  localparam int NUM_SRC = 4;
  localparam logic [7:0] INC_LOW_RST = 8'h01;
  localparam logic [7:0] INC_HIGH_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 20'h00000;
  localparam logic [PW_CNT_W-1:0] PW_ONE = 8'h01;
  localparam logic [1:0] LOAD_EDGES = 2'h2;
  localparam logic [1:0] SRC_FAST_OSC = 2'h0;
  localparam logic [1:0] SRC_SYS_OSC = 2'h1;
  localparam logic [1:0] SRC_LOGIC_CELL = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;

  typedef enum logic [1:0] {
    NCO_LD_IDLE = 2'b00,
    NCO_LD_WAIT = 2'b01
  } nco_load_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic clk_prev;
    logic [7:0] inc_low;
    logic [7:0] inc_high;
    logic [INC_W-1:0] inc_buf;
    nco_load_t load_st;
    logic [1:0] load_edges;
    logic [ACC_W-1:0] acc;
    logic toggle_ff;
    logic pulse_active;
    logic [PW_CNT_W-1:0] pulse_cnt;
    logic out_lvl;
    logic pin_out;
    logic overflow_pulse;
    logic flag;
  } nco_state_t;
endpackage

// *** verilog/nco_top.sv ***
// Numerically controlled oscillator core with plain control and status ports
`timescale 1ns/100ps
`default_nettype none
module nco_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Oscillator clock candidates, asynchronous to i_ref_clk
  input wire logic i_internal_fast_oscillator,
  input wire logic i_system_oscillator,
  input wire logic i_logic_cell_one_output,
  input wire logic i_external_clock_pin,
  // Control bits
  input wire logic i_module_enable_bit,
  input wire logic i_pin_output_enable,
  input wire logic i_output_polarity,
  input wire logic i_pulse_mode_select,
  input wire logic [2:0] i_pulse_width_select,
  input wire logic [1:0] i_clock_source_select,
  // Byte register writes
  input wire logic [7:0] i_wr_data,
  input wire logic i_increment_low_byte_wr,
  input wire logic i_increment_high_byte_wr,
  input wire logic i_accumulator_low_byte_wr,
  input wire logic i_accumulator_high_byte_wr,
  input wire logic i_accumulator_upper_bits_wr,
  input wire logic i_flag_clear,
  // Byte register readback
  output logic [7:0] o_increment_low_byte,
  output logic [7:0] o_increment_high_byte,
  output logic [7:0] o_accumulator_low_byte,
  output logic [7:0] o_accumulator_high_byte,
  output logic [7:0] o_accumulator_upper_bits,
  // Shaped output, pin and status
  output logic o_nco_out,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic o_overflow_pulse,
  output logic o_overflow_interrupt_flag
);
  nco_pkg::nco_state_t s_q;
  nco_pkg::nco_state_t s_d;
  logic [nco_pkg::NUM_SRC-1:0] src_raw;
  logic sel_lvl;
  logic osc_tick;
  logic [nco_pkg::ACC_W:0] sum;
  logic carry;
  logic shaped;

  assign src_raw = {i_external_clock_pin, i_logic_cell_one_output,
                    i_system_oscillator, i_internal_fast_oscillator};

  always_comb begin
    // Select after the second sync stage so the first stage feeds only the second
    sel_lvl = s_q.sync2[i_clock_source_select];
    osc_tick = sel_lvl & ~s_q.clk_prev & i_module_enable_bit;
    sum = {1'b0, s_q.acc} + {{(nco_pkg::ACC_W + 1 - nco_pkg::INC_W){1'b0}}, s_q.inc_buf};
    carry = osc_tick & sum[nco_pkg::ACC_W];

    s_d = s_q;
    s_d.sync1 = src_raw;
    s_d.sync2 = s_q.sync1;
    s_d.clk_prev = sel_lvl;
    s_d.overflow_pulse = carry;

    // Visible increment bytes
    if (i_increment_low_byte_wr) begin
      s_d.inc_low = i_wr_data;
    end
    if (i_increment_high_byte_wr) begin
      s_d.inc_high = i_wr_data;
    end

    // Hidden working buffer
    if (!i_module_enable_bit) begin
      s_d.load_st = nco_pkg::NCO_LD_IDLE;
      s_d.load_edges = 2'h0;
      if (i_increment_low_byte_wr || i_increment_high_byte_wr) begin
        s_d.inc_buf = {i_increment_high_byte_wr ? i_wr_data : s_q.inc_high,
                       i_increment_low_byte_wr ? i_wr_data : s_q.inc_low};
      end
    end else begin
      case (s_q.load_st)
        nco_pkg::NCO_LD_IDLE: begin
          if (i_increment_low_byte_wr) begin
            s_d.load_st = nco_pkg::NCO_LD_WAIT;
            s_d.load_edges = 2'h0;
          end
        end
        nco_pkg::NCO_LD_WAIT: begin
          if (i_increment_low_byte_wr) begin
            // A fresh low write restarts the two-edge wait
            s_d.load_edges = 2'h0;
          end else if (osc_tick) begin
            if (s_q.load_edges + 2'h1 == nco_pkg::LOAD_EDGES) begin
              s_d.inc_buf = {s_q.inc_high, s_q.inc_low};
              s_d.load_st = nco_pkg::NCO_LD_IDLE;
              s_d.load_edges = 2'h0;
            end else begin
              s_d.load_edges = s_q.load_edges + 2'h1;
            end
          end
        end
        default: begin
          s_d.load_st = nco_pkg::NCO_LD_IDLE;
        end
      endcase
    end

    // Accumulator: software writes win over the addition in the same cycle
    if (osc_tick) begin
      s_d.acc = sum[nco_pkg::ACC_W-1:0];
    end
    if (i_accumulator_low_byte_wr) begin
      s_d.acc[7:0] = i_wr_data;
    end
    if (i_accumulator_high_byte_wr) begin
      s_d.acc[15:8] = i_wr_data;
    end
    if (i_accumulator_upper_bits_wr) begin
      s_d.acc[19:16] = i_wr_data[3:0];
    end

    // Output shaping; a pulse longer than the overflow period is restarted
    if (carry) begin
      s_d.toggle_ff = ~s_q.toggle_ff;
      s_d.pulse_active = 1'b1;
      s_d.pulse_cnt = nco_pkg::PW_ONE << i_pulse_width_select;
    end else if (osc_tick && s_q.pulse_active) begin
      s_d.pulse_cnt = s_q.pulse_cnt - nco_pkg::PW_ONE;
      if (s_q.pulse_cnt == nco_pkg::PW_ONE) begin
        s_d.pulse_active = 1'b0;
      end
    end
    shaped = i_pulse_mode_select ? s_d.pulse_active : s_d.toggle_ff;
    s_d.out_lvl = shaped ^ i_output_polarity;
    s_d.pin_out = i_pin_output_enable & (shaped ^ i_output_polarity);

    // Sticky flag: a new overflow beats a clear in the same cycle
    if (carry) begin
      s_d.flag = 1'b1;
    end else if (i_flag_clear) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{sync1: '0, sync2: '0, clk_prev: 1'b0,
               inc_low: nco_pkg::INC_LOW_RST, inc_high: nco_pkg::INC_HIGH_RST,
               inc_buf: {nco_pkg::INC_HIGH_RST, nco_pkg::INC_LOW_RST},
               load_st: nco_pkg::NCO_LD_IDLE, load_edges: 2'h0,
               acc: nco_pkg::ACC_RST, toggle_ff: 1'b0, pulse_active: 1'b0,
               pulse_cnt: 8'h00, out_lvl: 1'b0, pin_out: 1'b0,
               overflow_pulse: 1'b0, flag: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_increment_low_byte = s_q.inc_low;
  assign o_increment_high_byte = s_q.inc_high;
  assign o_accumulator_low_byte = s_q.acc[7:0];
  assign o_accumulator_high_byte = s_q.acc[15:8];
  assign o_accumulator_upper_bits = {4'h0, s_q.acc[19:16]};
  assign o_nco_out = s_q.out_lvl;
  assign o_pin_out = s_q.pin_out;
  assign o_pin_oe_n = ~i_pin_output_enable;
  assign o_overflow_pulse = s_q.overflow_pulse;
  assign o_overflow_interrupt_flag = s_q.flag;
endmodule
`default_nettype wire
